// file: hdl/fcc_pkg.sv
// Package for the floppy control-command block: register map, command codes,
// timing constants. Assumes a 100 MHz system clock.
`default_nettype none
package fcc_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] REG_CMD      = 8'h00;
  localparam logic [7:0] REG_RESULT   = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_TIMING   = 8'h0c;
  localparam logic [7:0] REG_CONFIG   = 8'h10;
  localparam logic [7:0] REG_CYL      = 8'h14;
  localparam logic [7:0] REG_RATE     = 8'h18;
  localparam logic [7:0] REG_RWREQ    = 8'h1c;
  // ==========================================================
  // Command codes (CMD register bits [7:0])
  localparam logic [7:0] CMD_SENSE_DRIVE = 8'h04;
  localparam logic [7:0] CMD_SPECIFY     = 8'h03;
  localparam logic [7:0] CMD_CONFIGURE   = 8'h13;
  localparam logic [7:0] CMD_VERSION     = 8'h10;
  localparam logic [7:0] CMD_RECAL       = 8'h07;
  localparam logic [7:0] CMD_SEEK        = 8'h0f;
  localparam logic [7:0] CMD_REL_SEEK    = 8'h8f;
  localparam logic [7:0] CMD_SENSE_INT   = 8'h08;
  // ==========================================================
  // Defaults and fixed values
  localparam logic [3:0] HUT_RST         = 4'h0;
  localparam logic [3:0] SRT_RST         = 4'h0;
  localparam logic [6:0] HLT_RST         = 7'h00;
  localparam logic       AUTO_SEEK_RST   = 1'b0;
  localparam logic       FIFO_DIS_RST    = 1'b1;
  localparam logic       POLL_DIS_RST    = 1'b0;
  localparam logic [3:0] FIFO_THR_RST    = 4'h0;
  localparam logic [7:0] PRECOMP_RST     = 8'h00;
  localparam logic [7:0] RECAL_MAX_STEPS = 8'h4f;
  localparam logic [7:0] ST0_EC_MASK     = 8'h10;
  localparam logic [7:0] ST0_SE_MASK     = 8'h20;
  localparam logic [7:0] ST0_ABN_MASK    = 8'h40;
  localparam logic [7:0] ST0_POLL        = 8'hc0;
  localparam logic [31:0] AXI_OKAY       = 32'h0000_0000;
  // ==========================================================
  // Timing: base unit is 0.25 ms at 2 Mbps; 1M, 500K, 300K and 250K multiply it (MUL_250K is 64 eighths, times 8)
  localparam int CLK_MHZ      = 100;
  localparam int UNIT_US      = 250;
  localparam int UNIT_CYC     = UNIT_US * CLK_MHZ;
  localparam int STEP_PULSE_US  = 4;
  localparam int STEP_PULSE_CYC = STEP_PULSE_US * CLK_MHZ;
  // Rate code: 0=500K 1=300K 2=250K 3=1M 4=2M ; multiplier in eighths
  localparam logic [2:0] RATE_500K = 3'h0;
  localparam logic [2:0] RATE_300K = 3'h1;
  localparam logic [2:0] RATE_250K = 3'h2;
  localparam logic [2:0] RATE_1M   = 3'h3;
  localparam logic [2:0] RATE_2M   = 3'h4;
  localparam logic [5:0] MUL_500K  = 6'h20;
  localparam logic [5:0] MUL_300K  = 6'h35;
  localparam logic [5:0] MUL_250K  = 6'h40;
  localparam logic [5:0] MUL_1M    = 6'h10;
  localparam logic [5:0] MUL_2M    = 6'h08;
  localparam logic [7:0] VERSION_BYTE = 8'h5a; // Arbitrary value
endpackage : fcc_pkg
`default_nettype wire

// file: hdl/fcc_floppy_control.sv
// Floppy control-command interpreter: status query, timers, configure,
// version, seek, recalibrate, relative seek. AXI4-Lite slave for commands.
// Assumes one drive interface; track-0 input is synchronous to SYS_CLK_IN.
`default_nettype none
// Operation
// - Drive status goes straight to result
// - Head unload timer after read/write end
// - Step interval set by step code
// - Head load delay before read/write start
// - Delays scale with rate, same encodings; MUL_250K is 64 eighths, so the 250K unit is 8 times the 2M unit
// - Mode bit 1 non-DMA, 0 DMA
// - DMA request or ready bit signals transfer
// - Configure defaults after reset
// - Auto seek before read/write when enabled
// - FIFO disabled means byte requests; fifo_disable is only stored, one request per transfer
// - Polling enabled gives one reset interrupt
// - No polling while head loaded
// - Threshold is field plus one; fifo_threshold is only stored, never used
// - Precomp track taken directly
// - Version returns fixed byte
// - Relative seek steps count, dir bit
// - One relative seek at a time
// - Outward past track zero sets check
// - Cylinder wraps modulo 256
// - At most 255 cylinders per seek
// - Recal uses track zero, max steps
// - Commands use wrapped cylinder
module fcc_floppy_control #(
  parameter int UNIT_CYCLES       = fcc_pkg::UNIT_CYC,
  parameter int STEP_PULSE_CYCLES = fcc_pkg::STEP_PULSE_CYC
) (
  // Clock and reset
  input  wire  logic        SYS_CLK_IN,
  input  wire  logic        RESET_N_IN,
  // AXI4-Lite write
  input  wire  logic [7:0]  AWADDR_IN,
  input  wire  logic        AWVALID_IN,
  output var   logic        AWREADY_OUT,
  input  wire  logic [31:0] WDATA_IN,
  input  wire  logic [3:0]  WSTRB_IN,
  input  wire  logic        WVALID_IN,
  output var   logic        WREADY_OUT,
  output var   logic [1:0]  BRESP_OUT,
  output var   logic        BVALID_OUT,
  input  wire  logic        BREADY_IN,
  // AXI4-Lite read
  input  wire  logic [7:0]  ARADDR_IN,
  input  wire  logic        ARVALID_IN,
  output var   logic        ARREADY_OUT,
  output var   logic [31:0] RDATA_OUT,
  output var   logic [1:0]  RRESP_OUT,
  output var   logic        RVALID_OUT,
  input  wire  logic        RREADY_IN,
  // Drive
  input  wire  logic        TRACK0_N_IN,
  input  wire  logic        WRITE_PROT_IN,
  output var   logic        STEP_OUT,
  output var   logic        DIR_OUT,
  output var   logic        HEAD_LOAD_OUT,
  // Host signalling
  output var   logic        INT_OUT,
  output var   logic        DMA_REQ_OUT,
  output var   logic        RFM_OUT
);
  typedef enum logic [2:0] {FCC_IDLE, FCC_STEP_HI, FCC_STEP_GAP, FCC_HLOAD, FCC_XFER} fcc_state_t;
  fcc_state_t  state;
  logic [3:0]  head_unload_time, step_interval_code, fifo_threshold;
  logic [6:0]  head_load_delay;
  logic        no_dma_select, auto_seek_enable, fifo_disable, poll_disable;
  logic [7:0]  precomp_start_track, present_cylinder, target_cyl, steps_left, result, st0;
  logic [2:0]  rate;
  logic        dir, is_recal, is_rel, rel_busy, pending_rw, first_step, poll_done;
  logic [31:0] timer, hut_timer;
  logic        aw_hold, w_hold;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [5:0]  mul;
  // ==========================================================
  // Rate scaling: same for either encoding, only rate matters
  always_comb begin
    unique case (rate)
      fcc_pkg::RATE_300K: mul = fcc_pkg::MUL_300K;
      fcc_pkg::RATE_250K: mul = fcc_pkg::MUL_250K;
      fcc_pkg::RATE_1M:   mul = fcc_pkg::MUL_1M;
      fcc_pkg::RATE_2M:   mul = fcc_pkg::MUL_2M;
      default:            mul = fcc_pkg::MUL_500K;
    endcase
  end
  logic [31:0] unit_scaled, step_cyc, hut_cyc, hlt_cyc;
  assign unit_scaled = 32'((UNIT_CYCLES * int'(mul)) / 8);
  // Step code 0 means 16 units, hut code 0 means 256 units; HEAD_LOAD_DELAY code 0 means 128 units*2
  assign step_cyc = unit_scaled * 32'(5'h10 - {1'b0, step_interval_code});
  assign hut_cyc  = unit_scaled * 32'((head_unload_time == 4'h0) ? 9'h100
                                      : {1'b0, head_unload_time, 4'h0});
  assign hlt_cyc  = unit_scaled * 32'((head_load_delay == 7'h00) ? 8'h80
                                      : {1'b0, head_load_delay}) * 32'h2;
  // ==========================================================
  // AXI write channel: address and data in either order
  logic wr_fire;
  assign wr_fire = aw_hold && w_hold && !BVALID_OUT;
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      AWREADY_OUT <= 1'b0;
      WREADY_OUT <= 1'b0;
      BVALID_OUT <= 1'b0;
      BRESP_OUT <= 2'h0;
    end else begin
      AWREADY_OUT <= !aw_hold && !AWREADY_OUT;
      WREADY_OUT  <= !w_hold && !WREADY_OUT;
      if (AWVALID_IN && AWREADY_OUT) begin aw_hold <= 1'b1; aw_addr <= AWADDR_IN; end
      if (WVALID_IN && WREADY_OUT) begin w_hold <= 1'b1; w_data <= WDATA_IN; end
      if (wr_fire) begin
        BVALID_OUT <= 1'b1;
        BRESP_OUT  <= 2'h0;
        aw_hold    <= 1'b0;
        w_hold     <= 1'b0;
      end else if (BVALID_OUT && BREADY_IN) begin
        BVALID_OUT <= 1'b0;
      end
    end
  end
  // ==========================================================
  // AXI read channel
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ARREADY_OUT <= 1'b0;
      RVALID_OUT <= 1'b0;
      RDATA_OUT <= 32'h0000_0000;
      RRESP_OUT <= 2'h0;
    end else begin
      ARREADY_OUT <= !RVALID_OUT && !ARREADY_OUT;
      if (ARVALID_IN && ARREADY_OUT) begin
        RVALID_OUT <= 1'b1;
        RRESP_OUT  <= 2'h0;
        unique case (ARADDR_IN)
          fcc_pkg::REG_RESULT: RDATA_OUT <= {24'h000000, result};
          fcc_pkg::REG_STATUS: RDATA_OUT <= {16'h0000, st0, 3'h0, rel_busy, 1'b0,
                                             state == fcc_state_t'(FCC_IDLE), no_dma_select, RFM_OUT};
          fcc_pkg::REG_TIMING: RDATA_OUT <= {16'h0000, no_dma_select, head_load_delay,
                                             step_interval_code, head_unload_time};
          fcc_pkg::REG_CONFIG: RDATA_OUT <= {16'h0000, precomp_start_track, fifo_threshold,
                                             1'b0, auto_seek_enable, fifo_disable, poll_disable};
          fcc_pkg::REG_CYL:    RDATA_OUT <= {24'h000000, present_cylinder};
          fcc_pkg::REG_RATE:   RDATA_OUT <= {29'h00000000, rate};
          default:             RDATA_OUT <= fcc_pkg::AXI_OKAY;
        endcase
      end else if (RVALID_OUT && RREADY_IN) begin
        RVALID_OUT <= 1'b0;
      end
    end
  end
  // ==========================================================
  // Configuration registers written by commands; rate written through REG_RATE
  logic [7:0] wcmd;
  assign wcmd = w_data[7:0];
  logic cmd_fire;
  assign cmd_fire = wr_fire && aw_addr == fcc_pkg::REG_CMD && WSTRB_IN != 4'h0;
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      head_unload_time <= fcc_pkg::HUT_RST;
      step_interval_code <= fcc_pkg::SRT_RST;
      head_load_delay <= fcc_pkg::HLT_RST;
      no_dma_select <= 1'b0;
      auto_seek_enable <= fcc_pkg::AUTO_SEEK_RST;
      fifo_disable <= fcc_pkg::FIFO_DIS_RST;
      poll_disable <= fcc_pkg::POLL_DIS_RST;
      fifo_threshold <= fcc_pkg::FIFO_THR_RST;
      precomp_start_track <= fcc_pkg::PRECOMP_RST;
      rate <= fcc_pkg::RATE_500K;
    end else begin
      if (cmd_fire && wcmd == fcc_pkg::CMD_SPECIFY) begin
        head_unload_time   <= w_data[15:12];
        step_interval_code <= w_data[11:8];
        head_load_delay    <= w_data[23:17];
        no_dma_select      <= w_data[16];
      end
      if (cmd_fire && wcmd == fcc_pkg::CMD_CONFIGURE) begin
        auto_seek_enable    <= w_data[14];
        fifo_disable        <= w_data[13];
        poll_disable        <= w_data[12];
        fifo_threshold      <= w_data[11:8];
        precomp_start_track <= w_data[23:16];
      end
      if (wr_fire && aw_addr == fcc_pkg::REG_RATE) rate <= w_data[2:0];
    end
  end
  // ==========================================================
  // Command engine: seeks, recalibrate, head load and transfer
  logic rw_req;
  assign rw_req = wr_fire && aw_addr == fcc_pkg::REG_RWREQ;
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state <= FCC_IDLE;
      present_cylinder <= 8'h00;
      target_cyl <= 8'h00;
      steps_left <= 8'h00;
      result <= 8'h00;
      st0 <= 8'h00;
      dir <= 1'b0;
      is_recal <= 1'b0;
      is_rel <= 1'b0;
      rel_busy <= 1'b0;
      pending_rw <= 1'b0;
      first_step <= 1'b0;
      timer <= 32'h0;
      STEP_OUT <= 1'b0;
      DIR_OUT <= 1'b0;
      HEAD_LOAD_OUT <= 1'b0;
      INT_OUT <= 1'b0;
      DMA_REQ_OUT <= 1'b0;
      RFM_OUT <= 1'b0;
      hut_timer <= 32'h0;
      poll_done <= 1'b0;
    end else begin
      DIR_OUT <= dir;
      if (hut_timer != 32'h0) hut_timer <= hut_timer - 32'h1;
      else if (state != FCC_HLOAD && state != FCC_XFER) HEAD_LOAD_OUT <= 1'b0;
      // Single post-reset poll interrupt, held off while head loaded
      if (!poll_disable && !poll_done && !HEAD_LOAD_OUT) begin
        poll_done <= 1'b1;
        INT_OUT   <= 1'b1;
        st0       <= fcc_pkg::ST0_POLL;
      end
      if (cmd_fire && wcmd == fcc_pkg::CMD_SENSE_INT) begin
        INT_OUT <= 1'b0;
        result  <= st0;
      end
      if (cmd_fire && wcmd == fcc_pkg::CMD_SENSE_DRIVE)
        result <= {1'b0, WRITE_PROT_IN, 1'b1, !TRACK0_N_IN, 4'h0};
      if (cmd_fire && wcmd == fcc_pkg::CMD_VERSION)
        result <= fcc_pkg::VERSION_BYTE;
      unique case (state)
        FCC_IDLE: begin
          first_step <= 1'b1;
          if (cmd_fire && wcmd == fcc_pkg::CMD_REL_SEEK && !rel_busy) begin
            is_rel <= 1'b1;
            is_recal <= 1'b0;
            rel_busy <= 1'b1;
            dir <= w_data[16];
            steps_left <= w_data[15:8];
            st0 <= 8'h00; state <= FCC_STEP_GAP; timer <= 32'h1;
          end else if (cmd_fire && wcmd == fcc_pkg::CMD_SEEK) begin
            is_rel <= 1'b0; is_recal <= 1'b0; target_cyl <= w_data[15:8];
            st0 <= 8'h00; state <= FCC_STEP_GAP; timer <= 32'h1;
          end else if (cmd_fire && wcmd == fcc_pkg::CMD_RECAL) begin
            is_rel <= 1'b0;
            is_recal <= 1'b1;
            dir <= 1'b0;
            steps_left <= fcc_pkg::RECAL_MAX_STEPS; present_cylinder <= 8'h00;
            st0 <= 8'h00; state <= FCC_STEP_GAP; timer <= 32'h1;
          end else if (rw_req) begin
            pending_rw <= 1'b1;
            if (auto_seek_enable) begin
              target_cyl <= w_data[7:0]; is_rel <= 1'b0; is_recal <= 1'b0;
              state <= FCC_STEP_GAP; timer <= 32'h1;
            end else begin
              HEAD_LOAD_OUT <= 1'b1; timer <= hlt_cyc; state <= FCC_HLOAD;
            end
          end
        end
        FCC_STEP_GAP: begin
          if (timer > 32'h1) timer <= timer - 32'h1;
          else if (is_recal) begin
            if (TRACK0_N_IN == 1'b0) begin
              st0 <= fcc_pkg::ST0_SE_MASK; INT_OUT <= 1'b1; state <= FCC_IDLE;
            end else if (steps_left == 8'h00) begin
              st0 <= fcc_pkg::ST0_SE_MASK | fcc_pkg::ST0_EC_MASK | fcc_pkg::ST0_ABN_MASK;
              INT_OUT <= 1'b1; state <= FCC_IDLE;
            end else begin
              steps_left <= steps_left - 8'h01; STEP_OUT <= 1'b1;
              timer <= 32'(STEP_PULSE_CYCLES); state <= FCC_STEP_HI;
            end
          end else if (is_rel) begin
            if (steps_left == 8'h00) begin
              st0 <= st0 | fcc_pkg::ST0_SE_MASK; INT_OUT <= 1'b1;
              rel_busy <= 1'b0; state <= FCC_IDLE;
            end else if (!dir && TRACK0_N_IN == 1'b0) begin
              st0 <= fcc_pkg::ST0_SE_MASK | fcc_pkg::ST0_EC_MASK | fcc_pkg::ST0_ABN_MASK;
              INT_OUT <= 1'b1; rel_busy <= 1'b0; state <= FCC_IDLE;
            end else begin
              steps_left <= steps_left - 8'h01; STEP_OUT <= 1'b1;
              present_cylinder <= dir ? present_cylinder + 8'h01 : present_cylinder - 8'h01;
              timer <= 32'(STEP_PULSE_CYCLES); state <= FCC_STEP_HI;
            end
          end else if (present_cylinder == target_cyl) begin
            if (pending_rw) begin
              HEAD_LOAD_OUT <= 1'b1; timer <= hlt_cyc; state <= FCC_HLOAD;
            end else begin
              st0 <= fcc_pkg::ST0_SE_MASK; INT_OUT <= 1'b1; state <= FCC_IDLE;
            end
          end else begin
            dir <= present_cylinder < target_cyl; STEP_OUT <= 1'b1;
            present_cylinder <= (present_cylinder < target_cyl) ? present_cylinder + 8'h01
                                                                 : present_cylinder - 8'h01;
            timer <= 32'(STEP_PULSE_CYCLES); state <= FCC_STEP_HI;
          end
        end
        FCC_STEP_HI: begin
          if (timer > 32'h1) timer <= timer - 32'h1;
          else begin
            STEP_OUT <= 1'b0; first_step <= 1'b0; state <= FCC_STEP_GAP;
            // First gap may be shorter, it skips the pulse width
            timer <= first_step ? step_cyc - 32'(STEP_PULSE_CYCLES) : step_cyc;
          end
        end
        FCC_HLOAD: begin
          if (timer > 32'h1) timer <= timer - 32'h1;
          else begin
            state <= FCC_XFER;
            // One request held for the whole transfer: RFM_OUT and INT_OUT in non-DMA mode, else DMA_REQ_OUT
            if (no_dma_select) begin RFM_OUT <= 1'b1; INT_OUT <= 1'b1; end
            else DMA_REQ_OUT <= 1'b1;
          end
        end
        FCC_XFER: begin
          // Transfer ends on the host's acknowledging write to RWREQ
          if (rw_req) begin
            RFM_OUT <= 1'b0; DMA_REQ_OUT <= 1'b0; INT_OUT <= 1'b0;
            pending_rw <= 1'b0; hut_timer <= hut_cyc; state <= FCC_IDLE;
          end
        end
      endcase
    end
  end
  // ==========================================================
  // Checks
  AST_STEP_LIMIT: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    rel_busy && cmd_fire && wcmd == fcc_pkg::CMD_REL_SEEK |=> $stable(dir) && steps_left <= $past(steps_left))
    else $error("Overlapped relative seek");
  AST_EC_OUT: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (state == FCC_STEP_GAP && is_rel && timer <= 32'h1 && steps_left != 8'h00 && !dir && !TRACK0_N_IN)
    |=> st0[4]) else $error("Check flag missing");
  AST_DEFAULTS: assert property (@(posedge SYS_CLK_IN) $rose(RESET_N_IN) |-> fifo_disable
    && !auto_seek_enable && fifo_threshold == 4'h0) else $error("Bad defaults");
  AST_VERSION: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    cmd_fire && wcmd == fcc_pkg::CMD_VERSION |=> result == fcc_pkg::VERSION_BYTE) else $error("Version");
  AST_WRAP: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    $rose(STEP_OUT) && is_rel && dir |-> present_cylinder == $past(present_cylinder) + 8'h01)
    else $error("Cylinder not stepped");
  AST_DMA: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    $rose(DMA_REQ_OUT) |-> !no_dma_select) else $error("DMA in non-DMA mode");
  AST_RFM: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    $rose(RFM_OUT) |-> no_dma_select && INT_OUT) else $error("Ready without non-DMA");
  AST_HLOAD: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    state == FCC_XFER && $past(state) == FCC_HLOAD |-> HEAD_LOAD_OUT) else $error("No head load");
  // ==========================================================
  // Relative seek start, then armed in FCC_STEP_GAP the next cycle
  sequence fcc_rel_start_s;
    cmd_fire && wcmd == fcc_pkg::CMD_REL_SEEK && state == FCC_IDLE && !rel_busy;
  endsequence
  sequence fcc_rel_armed_s;
    rel_busy && is_rel && state == FCC_STEP_GAP;
  endsequence
  AST_REL_START: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    fcc_rel_start_s |=> fcc_rel_armed_s ##0 (dir == $past(w_data[16]))) else $error("Relative seek not armed");
  AST_HUT_HOLD: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    state == FCC_XFER && rw_req |=> HEAD_LOAD_OUT) else $error("Head unloaded too early");
  AST_POLL_INT: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    $rose(poll_done) |-> INT_OUT && st0 == fcc_pkg::ST0_POLL) else $error("Poll interrupt missing");
  AST_SENSE_DRIVE: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    cmd_fire && wcmd == fcc_pkg::CMD_SENSE_DRIVE |=> result[4] == !$past(TRACK0_N_IN) && result[5])
    else $error("Drive status wrong");
  AST_RECAL_LIMIT: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    is_recal && state == FCC_STEP_GAP |-> steps_left <= fcc_pkg::RECAL_MAX_STEPS) else $error("Recal overrun");
endmodule : fcc_floppy_control
`default_nettype wire

// file: dv/fcc_drive_model.sv
// =====================================
// Floppy drive model: head position follows the step and direction pins.
// Assumes one clean step pulse per step from the controller.
`default_nettype none
module fcc_drive_model #(
  parameter int START_TRACK = 0
) (
  // Drive pins
  input  wire logic step_in,
  input  wire logic dir_in,
  output var  logic track0_n_out,
  output var  logic wprot_out,
  // Observation
  output var  int   steps_out,
  output var  int   track_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    steps_out = 0;
    track_out = START_TRACK;
  end
  // Mechanical stop: head never goes below track 0
  always @(posedge step_in) begin
    steps_out <= steps_out + 1;
    if (dir_in) track_out <= track_out + 1;
    else if (track_out > 0) track_out <= track_out - 1;
  end
  assign track0_n_out = (track_out != 0);
  assign wprot_out = 1'b0;
endmodule : fcc_drive_model
`default_nettype wire

// file: dv/fcc_floppy_control_tb_top.sv
// =====================================
// Bench for the floppy control-command block, with a drive model.
// Assumes UNIT_CYCLES shortened to 4; waits bounded.
`default_nettype none
module fcc_floppy_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic SYS_CLK_IN = 0, RESET_N_IN = 0, AWVALID_IN = 0, WVALID_IN = 0, BREADY_IN = 0, ARVALID_IN = 0, RREADY_IN = 0;
  logic [7:0] AWADDR_IN = 8'h00, ARADDR_IN = 8'h00;
  logic [31:0] WDATA_IN = 32'h0, RDATA_OUT;
  logic [3:0] WSTRB_IN = 4'hf;
  logic [1:0] BRESP_OUT, RRESP_OUT;
  logic AWREADY_OUT, WREADY_OUT, BVALID_OUT, ARREADY_OUT, RVALID_OUT, TRACK0_N_IN, WRITE_PROT_IN;
  logic STEP_OUT, DIR_OUT, HEAD_LOAD_OUT, INT_OUT, DMA_REQ_OUT, RFM_OUT;
  int err_total = 0, total_checks = 0, steps, trk, s0;
  logic [31:0] rd, st, c0;
  always #5 SYS_CLK_IN = ~SYS_CLK_IN;
  fcc_floppy_control #(.UNIT_CYCLES(4), .STEP_PULSE_CYCLES(2)) dut_u (
    .SYS_CLK_IN(SYS_CLK_IN), .RESET_N_IN(RESET_N_IN), .AWADDR_IN(AWADDR_IN), .AWVALID_IN(AWVALID_IN),
    .AWREADY_OUT(AWREADY_OUT), .WDATA_IN(WDATA_IN), .WSTRB_IN(WSTRB_IN), .WVALID_IN(WVALID_IN),
    .WREADY_OUT(WREADY_OUT), .BRESP_OUT(BRESP_OUT), .BVALID_OUT(BVALID_OUT), .BREADY_IN(BREADY_IN),
    .ARADDR_IN(ARADDR_IN), .ARVALID_IN(ARVALID_IN), .ARREADY_OUT(ARREADY_OUT), .RDATA_OUT(RDATA_OUT),
    .RRESP_OUT(RRESP_OUT), .RVALID_OUT(RVALID_OUT), .RREADY_IN(RREADY_IN), .TRACK0_N_IN(TRACK0_N_IN),
    .WRITE_PROT_IN(WRITE_PROT_IN), .STEP_OUT(STEP_OUT), .DIR_OUT(DIR_OUT), .HEAD_LOAD_OUT(HEAD_LOAD_OUT),
    .INT_OUT(INT_OUT), .DMA_REQ_OUT(DMA_REQ_OUT), .RFM_OUT(RFM_OUT));
  fcc_drive_model drv_u (.step_in(STEP_OUT), .dir_in(DIR_OUT), .track0_n_out(TRACK0_N_IN),
                         .wprot_out(WRITE_PROT_IN), .steps_out(steps), .track_out(trk));
  // =====================================
  // Reporting
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic hang(input string nm);
    err_total++;
    $display("MISMATCH %s expected answer seen timeout", nm);
    wrap_up();
  endtask : hang
  // =====================================
  // AXI4-Lite master
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    AWADDR_IN <= a;
    WDATA_IN <= d;
    AWVALID_IN <= 1'b1;
    WVALID_IN <= 1'b1;
    BREADY_IN <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge SYS_CLK_IN);
      if (AWVALID_IN && AWREADY_OUT) AWVALID_IN <= 1'b0;
      if (WVALID_IN && WREADY_OUT) WVALID_IN <= 1'b0;
      if (BVALID_OUT) break;
    end
    if (n == 100) hang("bvalid");
    BREADY_IN <= 1'b0;
    chk("bresp", {30'h0, BRESP_OUT}, 32'h0);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    ARADDR_IN <= a;
    ARVALID_IN <= 1'b1;
    RREADY_IN <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge SYS_CLK_IN);
      if (ARVALID_IN && ARREADY_OUT) ARVALID_IN <= 1'b0;
      if (RVALID_OUT) break;
    end
    if (n == 100) hang("rvalid");
    d = RDATA_OUT;
    RREADY_IN <= 1'b0;
  endtask : axi_rd
  task automatic cmd(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
    axi_wr(fcc_pkg::REG_CMD, {8'h00, b2, b1, op});
  endtask : cmd
  // Waits for the completion interrupt, keeps status, then clears it
  task automatic wait_int;
    int n;
    for (n = 0; n < 20000 && INT_OUT !== 1'b1; n++) @(posedge SYS_CLK_IN);
    if (n == 20000) hang("int");
    axi_rd(fcc_pkg::REG_STATUS, st);
    cmd(fcc_pkg::CMD_SENSE_INT, 8'h00, 8'h00);
  endtask : wait_int
  // =====================================
  // Scenarios
  task automatic t_reset;
    wait_int();
    axi_rd(fcc_pkg::REG_CONFIG, rd);
    chk("config default", rd, 32'h0000_0002);
    chk("int cleared", {31'h0, INT_OUT}, 32'h0);
    axi_rd(8'hfc, rd);
    chk("unmapped", rd, 32'h0);
  endtask : t_reset
  task automatic t_query;
    cmd(fcc_pkg::CMD_VERSION, 8'h00, 8'h00);
    axi_rd(fcc_pkg::REG_RESULT, rd);
    chk("version", rd & 32'hff, {24'h0, fcc_pkg::VERSION_BYTE});
    cmd(fcc_pkg::CMD_SENSE_DRIVE, 8'h00, 8'h00);
    axi_rd(fcc_pkg::REG_RESULT, rd);
    chk("drive status", rd & 32'hff, 32'h30);
    axi_rd(fcc_pkg::REG_STATUS, rd);
    chk("drive status idle", rd & 32'h4, 32'h4);
  endtask : t_query
  task automatic t_setup;
    cmd(fcc_pkg::CMD_CONFIGURE, 8'h5f, 8'hff);
    axi_rd(fcc_pkg::REG_CONFIG, rd);
    chk("config set", rd, 32'h0000_fff5);
    axi_wr(fcc_pkg::REG_RATE, {29'h0, fcc_pkg::RATE_2M});
    cmd(fcc_pkg::CMD_SPECIFY, 8'h0f, 8'h03);
    axi_rd(fcc_pkg::REG_STATUS, rd);
    chk("nodma set", rd & 32'h2, 32'h2);
    cmd(fcc_pkg::CMD_SPECIFY, 8'h0f, 8'h02);
    axi_rd(fcc_pkg::REG_STATUS, rd);
    chk("nodma clear", rd & 32'h2, 32'h0);
  endtask : t_setup
  // Implied seek to track 0, head load, DMA request, host acknowledge
  task automatic t_xfer;
    int n;
    axi_wr(fcc_pkg::REG_RWREQ, 32'h0);
    for (n = 0; n < 2000 && DMA_REQ_OUT !== 1'b1; n++) @(posedge SYS_CLK_IN);
    if (n == 2000) hang("dmareq");
    chk("head load", {31'h0, HEAD_LOAD_OUT}, 32'h1);
    chk("no rfm in dma", {31'h0, RFM_OUT}, 32'h0);
    axi_wr(fcc_pkg::REG_RWREQ, 32'h0);
    chk("dma done", {31'h0, DMA_REQ_OUT}, 32'h0);
    chk("head held", {31'h0, HEAD_LOAD_OUT}, 32'h1);
  endtask : t_xfer
  task automatic t_recal(input logic [7:0] ec);
    s0 = steps;
    cmd(fcc_pkg::CMD_RECAL, 8'h00, 8'h00);
    wait_int();
    chk("recal check", {24'h0, st[15:8] & fcc_pkg::ST0_EC_MASK}, {24'h0, ec});
    chk("recal steps", {31'h0, steps - s0 <= 80}, 32'h1);
  endtask : t_recal
  task automatic t_rel_out;
    cmd(fcc_pkg::CMD_REL_SEEK, 8'h03, 8'h00);
    wait_int();
    chk("outward check", {24'h0, st[15:8] & fcc_pkg::ST0_EC_MASK}, 32'h10);
  endtask : t_rel_out
  // Second relative seek while one is busy must be ignored
  task automatic t_rel_busy;
    axi_rd(fcc_pkg::REG_CYL, c0);
    s0 = steps;
    cmd(fcc_pkg::CMD_REL_SEEK, 8'h05, 8'h01);
    cmd(fcc_pkg::CMD_REL_SEEK, 8'h07, 8'h01);
    wait_int();
    chk("busy steps", steps - s0, 32'd5);
    axi_rd(fcc_pkg::REG_CYL, rd);
    chk("busy cyl", rd & 32'hff, (c0 + 32'd5) & 32'hff);
  endtask : t_rel_busy
  task automatic t_rel_wrap;
    axi_rd(fcc_pkg::REG_CYL, c0);
    s0 = steps;
    cmd(fcc_pkg::CMD_REL_SEEK, 8'hff, 8'h01);
    wait_int();
    chk("dir in", {31'h0, DIR_OUT}, 32'h1);
    cmd(fcc_pkg::CMD_REL_SEEK, 8'h02, 8'h01);
    wait_int();
    chk("wrap steps", steps - s0, 32'd257);
    axi_rd(fcc_pkg::REG_CYL, rd);
    chk("wrap cyl", rd & 32'hff, (c0 + 32'd257) & 32'hff);
  endtask : t_rel_wrap
  initial begin
    repeat (4) @(posedge SYS_CLK_IN);
    RESET_N_IN <= 1'b1;
    repeat (2) @(posedge SYS_CLK_IN);
    t_reset();
    t_query();
    t_setup();
    t_xfer();
    t_recal(8'h00);
    t_rel_out();
    t_rel_busy();
    t_rel_wrap();
    t_recal(fcc_pkg::ST0_EC_MASK);
    wrap_up();
  end
endmodule : fcc_floppy_control_tb_top
`default_nettype wire
